// [shared/pwm_timer_cfg.svh]
// Offsets, field positions, reset values and codes of the two-channel timer.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one word per register.
`ifndef PWM_TIMER_CFG_SVH
`define PWM_TIMER_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_STATUS_CONTROL 8'h00
`define OFS_COUNTER_HIGH 8'h04
`define OFS_COUNTER_LOW 8'h08
`define OFS_PERIOD_LIMIT 8'h0c
`define OFS_CH0_STATUS 8'h10
`define OFS_CH1_STATUS 8'h14
`define OFS_CH0_COMPARE 8'h18
`define OFS_CH1_COMPARE 8'h1c

// ----------------------------------------
// Status and control fields
// ----------------------------------------
`define SC_WRAP_FLAG 7
`define SC_WRAP_IRQ_EN 6
`define SC_HALT 5
`define SC_CLEAR 4
`define SC_DIV_HI 2
`define HALT_RESET 1'b1
`define DIV_UNAVAILABLE 3'h7

// ----------------------------------------
// Channel status and control fields
// ----------------------------------------
`define CH_EVENT_FLAG 7
`define CH_IRQ_EN 6
`define CH_BUFFERED 5
`define CH_UNBUFFERED 4
`define CH_EDGE_HI 3
`define CH_EDGE_LO 2
`define CH_TOGGLE_WRAP 1
`define CH_FULL_DUTY 0
`define ELS_NONE 2'h0
`define ELS_TOGGLE 2'h1
`define ELS_CLEAR 2'h2
`define ELS_SET 2'h3

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define PERIOD_RESET 16'hffff
`define COMPARE_RESET 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [shared/pwm_timer_pkg.sv]
// Types shared by the two-channel timer.
// Assumes the constants header is included by the users of these types.
package pwm_timer_pkg;

    // ----------------------------------------
    // Channel function
    // ----------------------------------------
    typedef enum logic [1:0] {
        MODE_PRESET,
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_LINKED
    } chan_mode_t;

endpackage

// [rtl/two_channel_pwm_timer_core.sv]
// Two-channel 16-bit timer with PWM, capture, wrap flag and latched read.
// Assumes an AXI4-Lite master, synchronous pins and wait/break controls.
//
// Summary of operation
// - Channel 0 buffered bit links both channels; it overrides unbuffered.
// - Without toggle-on-wrap, wrap leaves pin alone; ELS_CLEAR on compare then gives 0% duty.
// - Full-duty bit with toggle-on-wrap yields 100% duty with ELS_CLEAR, 0% with other edge codes.
// - Wrap flag with its enable raises the interrupt request.
// - Capture or compare sets channel flag; enabled flag requests interrupt.
// - In wait mode timer runs, bus access refused, interrupts wake.
// - Debug break freezes the counter and blocks captures.
// - Break with clear disabled: accesses leave flags; armed clear survives.
// - Break with clear enabled: flags clearable and stay cleared.
// - Wrap flag sets at period; read-then-write-0 clears; events void it.
// - Halt stops counting; reset sets halt, clears flag and enable.
// - Halt blocks captures on capture channels.
// - Clear bit zeroes counter and prescaler, self-clears, reads zero.
// - Halt and clear together leave counter stopped at zero.
// - Divider select picks bus clock over 1 to 64; code 7 stops.
// - High-byte read latches low byte until low byte is read.
// - Counter registers zeroed by reset and by the clear bit.
// - Pins independently capture or compare; only channel 0 is buffered.
// - Counter restarts at period; high period write holds off wrap flag.
// - Channel flag read-then-write-0 clear; new event voids it.
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "pwm_timer_cfg.svh"

module two_channel_pwm_timer_core
    import pwm_timer_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // System controls
    input wire logic wait_mode_in,
    input wire logic break_active_in,
    input wire logic break_clear_enable_in,
    // Channel pins
    input wire logic [1:0] channel_pin_in,
    output logic [1:0] channel_pin_out,
    output logic [1:0] channel_pin_oe_out,
    // Requests
    output logic irq_out,
    output logic wake_out
);

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic wr_ok;
    logic rd_fire;
    logic rd_ok;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_hit;
    logic wr_hit;

    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid_out;
    assign wr_ok = wr_fire && !wait_mode_in;
    assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;
    assign rd_ok = rd_fire && !wait_mode_in;
    assign rd_addr = s_axi_araddr_in;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            s_axi_awready_out <= 1'b0;
        end else begin
            s_axi_awready_out <= s_axi_awvalid_in && !aw_held_q &&
                !s_axi_awready_out;
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr_in;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_wready_out <= 1'b0;
        end else begin
            s_axi_wready_out <= s_axi_wvalid_in && !w_held_q &&
                !s_axi_wready_out;
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata_in;
                w_strb_q <= s_axi_wstrb_in;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Refused and unmapped accesses both answer SLVERR
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (wr_ok && wr_hit) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0;
            s_axi_rresp_out <= `RESP_OKAY;
        end else begin
            s_axi_arready_out <= s_axi_arvalid_in && !s_axi_arready_out &&
                !s_axi_rvalid_out;
            if (rd_fire) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= (rd_ok && rd_hit) ? rd_data : 32'h0;
                s_axi_rresp_out <= (rd_ok && rd_hit) ? `RESP_OKAY :
                    `RESP_SLVERR;
            end else if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    assign wr_hit = aw_addr_q <= `OFS_CH1_COMPARE && aw_addr_q[1:0] == 2'h0;
    assign rd_hit = rd_addr <= `OFS_CH1_COMPARE && rd_addr[1:0] == 2'h0;

    // ----------------------------------------
    // Decoded accesses
    // ----------------------------------------
    logic sc_wr;
    logic sc_rd;
    logic per_wr;
    logic protect;
    logic do_clear;

    assign sc_wr = wr_ok && aw_addr_q == `OFS_STATUS_CONTROL && w_strb_q[0];
    assign sc_rd = rd_ok && rd_addr == `OFS_STATUS_CONTROL;
    assign per_wr = wr_ok && aw_addr_q == `OFS_PERIOD_LIMIT;
    assign protect = break_active_in && !break_clear_enable_in;
    assign do_clear = sc_wr && w_data_q[`SC_CLEAR];

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic halt_q;
    logic wrap_irq_en_q;
    logic [2:0] div_sel_q;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            halt_q <= `HALT_RESET;
            wrap_irq_en_q <= 1'b0;
            div_sel_q <= 3'h0;
        end else if (sc_wr) begin
            halt_q <= w_data_q[`SC_HALT];
            wrap_irq_en_q <= w_data_q[`SC_WRAP_IRQ_EN];
            div_sel_q <= w_data_q[`SC_DIV_HI:0];
        end
    end

    // ----------------------------------------
    // Prescaler and counter
    // ----------------------------------------
    logic [5:0] presc_q;
    logic [6:0] div_mask;
    logic tick;
    logic advance;
    logic wrap;
    logic [15:0] count_q;
    logic [15:0] period_q;
    logic hold_off_q;

    assign div_mask = 7'(7'h1 << div_sel_q) - 7'h1;
    assign tick = div_sel_q != `DIV_UNAVAILABLE &&
        (presc_q & div_mask[5:0]) == div_mask[5:0];
    assign advance = tick && !halt_q && !break_active_in;
    assign wrap = advance && count_q == period_q;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || do_clear) begin
            presc_q <= 6'h0;
        end else begin
            presc_q <= presc_q + 6'h1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || do_clear) begin
            count_q <= 16'h0;
        end else if (wrap) begin
            count_q <= 16'h0;
        end else if (advance) begin
            count_q <= count_q + 16'h1;
        end
    end

    // High byte alone holds off the wrap flag until the low byte lands
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            period_q <= `PERIOD_RESET;
            hold_off_q <= 1'b0;
        end else if (per_wr) begin
            if (w_strb_q[1]) begin
                period_q[15:8] <= w_data_q[15:8];
            end
            if (w_strb_q[0]) begin
                period_q[7:0] <= w_data_q[7:0];
            end
            hold_off_q <= w_strb_q[1] && !w_strb_q[0];
        end
    end

    // ----------------------------------------
    // Latched counter read
    // ----------------------------------------
    logic latched_q;
    logic [7:0] low_buf_q;

    // Left latched across a break if software never reads the low byte
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || do_clear) begin
            latched_q <= 1'b0;
            low_buf_q <= 8'h0;
        end else if (rd_ok && rd_addr == `OFS_COUNTER_LOW) begin
            latched_q <= 1'b0;
        end else if (rd_ok && rd_addr == `OFS_COUNTER_HIGH && !latched_q) begin
            latched_q <= 1'b1;
            low_buf_q <= count_q[7:0];
        end
    end

    // ----------------------------------------
    // Wrap flag
    // ----------------------------------------
    logic wrap_flag_q;
    logic wrap_armed_q;
    logic wrap_set;

    assign wrap_set = wrap && !hold_off_q;

    // Set wins over a clear in the same cycle
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            wrap_flag_q <= 1'b0;
            wrap_armed_q <= 1'b0;
        end else if (wrap_set) begin
            wrap_flag_q <= 1'b1;
            wrap_armed_q <= 1'b0;
        end else if (sc_wr && !protect && wrap_armed_q &&
                !w_data_q[`SC_WRAP_FLAG]) begin
            wrap_flag_q <= 1'b0;
            wrap_armed_q <= 1'b0;
        end else if (sc_rd && !protect && wrap_flag_q) begin
            wrap_armed_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    logic [6:0] ch_ctrl_q [2];
    logic [15:0] cmp_q [2];
    logic [1:0] ch_flag_q;
    logic [1:0] ch_irq;
    logic [1:0] pin_prev_q;
    logic link;
    logic active_sel_q;
    logic next_sel_q;
    logic [15:0] linked_cmp;

    assign link = ch_ctrl_q[0][`CH_BUFFERED];
    assign linked_cmp = cmp_q[active_sel_q];

    // Last compare written takes over at the next wrap
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            active_sel_q <= 1'b0;
            next_sel_q <= 1'b0;
        end else begin
            if (wr_ok && aw_addr_q == `OFS_CH1_COMPARE) begin
                next_sel_q <= 1'b1;
            end else if (wr_ok && aw_addr_q == `OFS_CH0_COMPARE) begin
                next_sel_q <= 1'b0;
            end
            if (!link) begin
                active_sel_q <= 1'b0;
            end else if (wrap) begin
                active_sel_q <= next_sel_q;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pin_prev_q <= 2'h3; // Pulled-up idle level, no false edge
        end else begin
            pin_prev_q <= channel_pin_in;
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_ch
        localparam logic [7:0] SC_OFS = (i == 0) ? `OFS_CH0_STATUS :
            `OFS_CH1_STATUS;
        localparam logic [7:0] CMP_OFS = (i == 0) ? `OFS_CH0_COMPARE :
            `OFS_CH1_COMPARE;
        chan_mode_t mode;
        logic [1:0] els;
        logic off;
        logic edge_hit;
        logic capture;
        logic hit;
        logic event_set;
        logic armed_q;
        logic sc_sel_wr;
        logic pulse_lvl;

        assign els = ch_ctrl_q[i][`CH_EDGE_HI:`CH_EDGE_LO];
        assign off = (i == 1) && link;
        assign sc_sel_wr = wr_ok && aw_addr_q == SC_OFS && w_strb_q[0];
        assign pulse_lvl = els == `ELS_CLEAR;

        // Buffered bit overrides the unbuffered bit
        always_comb begin
            if (i == 0 && link) begin
                mode = MODE_LINKED;
            end else if (els == `ELS_NONE) begin
                mode = MODE_PRESET;
            end else if (ch_ctrl_q[i][`CH_UNBUFFERED]) begin
                mode = MODE_COMPARE;
            end else begin
                mode = MODE_CAPTURE;
            end
        end

        always_comb begin
            unique case (els)
                `ELS_TOGGLE: edge_hit = channel_pin_in[i] && !pin_prev_q[i];
                `ELS_CLEAR: edge_hit = !channel_pin_in[i] && pin_prev_q[i];
                `ELS_SET: edge_hit = channel_pin_in[i] != pin_prev_q[i];
                default: edge_hit = 1'b0;
            endcase
        end

        assign capture = !off && mode == MODE_CAPTURE && edge_hit &&
            !halt_q && !break_active_in;
        assign hit = !off && advance && (mode == MODE_COMPARE ||
            mode == MODE_LINKED) &&
            count_q == ((mode == MODE_LINKED) ? linked_cmp : cmp_q[i]);
        assign event_set = capture || hit;

        always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
                ch_ctrl_q[i] <= 7'h0;
            end else if (sc_sel_wr) begin
                ch_ctrl_q[i] <= w_data_q[6:0] &
                    ((i == 0) ? 7'h7f : 7'h5f);
            end
        end

        always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
                cmp_q[i] <= `COMPARE_RESET;
            end else if (capture) begin
                cmp_q[i] <= count_q;
            end else if (wr_ok && aw_addr_q == CMP_OFS) begin
                if (w_strb_q[1]) begin
                    cmp_q[i][15:8] <= w_data_q[15:8];
                end
                if (w_strb_q[0]) begin
                    cmp_q[i][7:0] <= w_data_q[7:0];
                end
            end
        end

        // A new event voids a pending clear
        always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
                ch_flag_q[i] <= 1'b0;
                armed_q <= 1'b0;
            end else if (event_set) begin
                ch_flag_q[i] <= 1'b1;
                armed_q <= 1'b0;
            end else if (sc_sel_wr && !protect && armed_q &&
                    !w_data_q[`CH_EVENT_FLAG]) begin
                ch_flag_q[i] <= 1'b0;
                armed_q <= 1'b0;
            end else if (rd_ok && rd_addr == SC_OFS && !protect &&
                    ch_flag_q[i]) begin
                armed_q <= 1'b1;
            end
        end

        assign ch_irq[i] = ch_flag_q[i] && ch_ctrl_q[i][`CH_IRQ_EN];

        // With toggle-on-wrap set, wrap beats a compare in the same cycle
        always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
                channel_pin_out[i] <= 1'b0;
                channel_pin_oe_out[i] <= 1'b0;
            end else begin
                channel_pin_oe_out[i] <= !off && (mode == MODE_COMPARE ||
                    mode == MODE_LINKED);
                unique case (mode)
                    MODE_PRESET: begin
                        channel_pin_out[i] <= !ch_ctrl_q[i][`CH_UNBUFFERED];
                    end
                    MODE_CAPTURE: begin
                        channel_pin_out[i] <= channel_pin_out[i];
                    end
                    MODE_COMPARE, MODE_LINKED: begin
                        if (wrap && ch_ctrl_q[i][`CH_TOGGLE_WRAP]) begin
                            if (ch_ctrl_q[i][`CH_FULL_DUTY]) begin
                                channel_pin_out[i] <= pulse_lvl;
                            end else begin
                                channel_pin_out[i] <= !channel_pin_out[i];
                            end
                        end else if (hit && !(ch_ctrl_q[i][`CH_FULL_DUTY] &&
                                ch_ctrl_q[i][`CH_TOGGLE_WRAP])) begin
                            unique case (els)
                                `ELS_TOGGLE: begin
                                    channel_pin_out[i] <= !channel_pin_out[i];
                                end
                                `ELS_CLEAR: channel_pin_out[i] <= 1'b0;
                                `ELS_SET: channel_pin_out[i] <= 1'b1;
                                default: channel_pin_out[i] <= 1'b0;
                            endcase
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Read mux and requests
    // ----------------------------------------
    always_comb begin
        rd_data = 32'h0;
        unique case (rd_addr)
            `OFS_STATUS_CONTROL: begin
                rd_data[7:0] = {wrap_flag_q, wrap_irq_en_q, halt_q, 2'b00,
                    div_sel_q};
            end
            `OFS_COUNTER_HIGH: rd_data[7:0] = count_q[15:8];
            `OFS_COUNTER_LOW: begin
                rd_data[7:0] = latched_q ? low_buf_q : count_q[7:0];
            end
            `OFS_PERIOD_LIMIT: rd_data[15:0] = period_q;
            `OFS_CH0_STATUS: rd_data[7:0] = {ch_flag_q[0], ch_ctrl_q[0]};
            `OFS_CH1_STATUS: rd_data[7:0] = {ch_flag_q[1], ch_ctrl_q[1]};
            `OFS_CH0_COMPARE: rd_data[15:0] = cmp_q[0];
            `OFS_CH1_COMPARE: rd_data[15:0] = cmp_q[1];
            default: rd_data = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
            wake_out <= 1'b0;
        end else begin
            irq_out <= (wrap_flag_q && wrap_irq_en_q) || (|ch_irq);
            wake_out <= wait_mode_in &&
                ((wrap_flag_q && wrap_irq_en_q) || (|ch_irq));
        end
    end

endmodule

// [verification/pin_model.sv]
// Pin side of the timer: pulled-up lines, loopback when driven.
// Assumes oe high while the timer drives a pin.
`timescale 1ns/1ps
module pin_model (
    // Timer side
    input wire logic [1:0] pin_out_in,
    input wire logic [1:0] pin_oe_in,
    // Line levels
    output logic [1:0] pin_level_out
);
    // Released lines float up to the pull-up level
    assign pin_level_out = (pin_out_in & pin_oe_in) | ~pin_oe_in;
endmodule

// [verification/pwm_timer_asserts.sv]
// Checker on the timer's bus, request and pin ports.
// Assumes wait_mode_in is held steady around each bus access.
`timescale 1ns/1ps
module pwm_timer_asserts (
    // Clock, reset and bus
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out,
    input wire logic s_axi_rvalid_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    // Controls and requests
    input wire logic wait_mode_in,
    input wire logic [1:0] channel_pin_oe_out,
    input wire logic irq_out,
    input wire logic wake_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_wr_ref;
        $rose(s_axi_bvalid_out) && $past(wait_mode_in)
            |-> s_axi_bresp_out == 2'h2;
    endproperty
    a_wr_ref: assert property (p_wr_ref) else $error("write not refused");
    property p_rd_ref;
        s_axi_arvalid_in && s_axi_arready_out && wait_mode_in
            |=> s_axi_rvalid_out && s_axi_rresp_out == 2'h2;
    endproperty
    a_rd_ref: assert property (p_rd_ref) else $error("read not refused");
    property p_wake_src;
        wake_out |-> irq_out && $past(wait_mode_in);
    endproperty
    a_wake_src: assert property (p_wake_src) else $error("stray wake");
    property p_wake_on;
        wait_mode_in |=> wake_out == irq_out;
    endproperty
    a_wake_on: assert property (p_wake_on) else $error("no wake");
    property p_rst;
        $rose(rst_n_in) |-> !irq_out && channel_pin_oe_out == 2'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs live at reset");
    property p_clr0;
        s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == 8'h00
            |=> s_axi_rdata_out[4] == 1'b0;
    endproperty
    a_clr0: assert property (p_clr0) else $error("clear bit reads 1");
    property p_irq_wrap;
        $rose(s_axi_rvalid_out) && $past(s_axi_araddr_in) == 8'h00 &&
            s_axi_rresp_out == 2'h0 && s_axi_rdata_out[7:6] == 2'h3 |-> irq_out;
    endproperty
    a_irq_wrap: assert property (p_irq_wrap) else $error("no wrap irq");
    property p_irq_ch;
        $rose(s_axi_rvalid_out) && $past(s_axi_araddr_in) == 8'h10 &&
            s_axi_rresp_out == 2'h0 && s_axi_rdata_out[7:6] == 2'h3 |-> irq_out;
    endproperty
    a_irq_ch: assert property (p_irq_ch) else $error("no channel irq");
    c_irq: cover property (irq_out);
    c_wake: cover property (wake_out);
    c_ref: cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'h2);
endmodule

bind two_channel_pwm_timer_core pwm_timer_asserts i_asserts (.*);

// [verification/tb.sv]
// Bench: register-level tests of the two-channel timer over AXI4-Lite.
// Assumes pins pulled up when released and registered bus answers.
`timescale 1ns/1ps
module tb;
    logic sys_clk_in, rst_n_in, s_axi_awvalid_in, s_axi_awready_out;
    logic s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out;
    logic s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
    logic s_axi_rvalid_out, s_axi_rready_in, wait_mode_in, irq_out;
    logic break_active_in, break_clear_enable_in, wake_out;
    logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out, d, l1, hi;
    logic [3:0] s_axi_wstrb_in;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r, channel_pin_in;
    logic [1:0] channel_pin_out, channel_pin_oe_out;
    int bad_count, check_count;
    two_channel_pwm_timer_core i_dut (.*);
    pin_model i_pins (.pin_out_in(channel_pin_out),
        .pin_oe_in(channel_pin_oe_out), .pin_level_out(channel_pin_in));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
            bad_count++;
        end
    endtask
    // Bounded waits end the run rather than hang
    task automatic tmo(input int n);
        if (n >= 200) begin
            bad_count++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= v;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            n++;
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (s_axi_bvalid_out !== 1'b1 && n < 200);
        r = s_axi_bresp_out;
        tmo(n);
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            n++;
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (s_axi_rvalid_out !== 1'b1 && n < 200);
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
        tmo(n);
    endtask
    task automatic wirq;
        int n;
        n = 0;
        while (irq_out !== 1'b1 && n < 200) begin
            @(posedge sys_clk_in);
            n++;
        end
        tmo(n);
    endtask
    task automatic cnt_hi;
        hi = 32'h0;
        repeat (32) begin
            @(posedge sys_clk_in);
            hi += channel_pin_in[0];
        end
    endtask
    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        {rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in} = 3'h0;
        {s_axi_arvalid_in, wait_mode_in, break_active_in} = 3'h0;
        break_clear_enable_in = 1'b0;
        {s_axi_bready_in, s_axi_rready_in} = 2'h3;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
        s_axi_wstrb_in = 4'hf;
        repeat (8) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        rd(8'h00); chk(32'h20, d);
        rd(8'h08); chk(32'h0, d);
        rd(8'h40); chk(32'h2, r);
        $display("reset test done");
        wr(8'h0c, 32'h3);
        wr(8'h00, 32'h40);
        wirq();
        // Unarmed write of zero must leave the flag set
        wr(8'h00, 32'h60);
        rd(8'h00); chk(32'he0, d);
        wr(8'h00, 32'h60);
        rd(8'h00); chk(32'h60, d);
        chk(32'h0, irq_out);
        wr(8'h00, 32'h30);
        rd(8'h04); chk(32'h0, d);
        rd(8'h08); chk(32'h0, d);
        wr(8'h00, 32'h17);
        repeat (20) @(posedge sys_clk_in);
        rd(8'h00); chk(32'h07, d);
        rd(8'h08); chk(32'h0, d);
        wr(8'h0c, 32'hffff);
        wr(8'h00, 32'h16);
        rd(8'h04);
        repeat (300) @(posedge sys_clk_in);
        rd(8'h08); l1 = d;
        rd(8'h08); chk(32'h2, (d - l1) >> 1);
        $display("counter test done");
        wr(8'h0c, 32'h3);
        wr(8'h00, 32'h10);
        repeat (10) @(posedge sys_clk_in);
        break_active_in <= 1'b1;
        rd(8'h04); rd(8'h08); l1 = d;
        repeat (11) @(posedge sys_clk_in);
        rd(8'h04); rd(8'h08); chk(l1, d);
        rd(8'h00); wr(8'h00, 32'h00);
        rd(8'h00); chk(32'h80, d);
        break_clear_enable_in <= 1'b1;
        rd(8'h00); wr(8'h00, 32'h20);
        break_active_in <= 1'b0;
        rd(8'h00); chk(32'h20, d);
        $display("break test done");
        wr(8'h00, 32'h50);
        wirq();
        wait_mode_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        chk(32'h1, wake_out);
        wr(8'h00, 32'h20); chk(32'h2, r);
        rd(8'h00); chk(32'h2, r);
        wait_mode_in <= 1'b0;
        $display("wait test done");
        wr(8'h00, 32'h30);
        wr(8'h0c, 32'h7);
        wr(8'h18, 32'h3);
        wr(8'h10, 32'h5a);
        wr(8'h00, 32'h00);
        repeat (40) @(posedge sys_clk_in);
        rd(8'h10); chk(32'hda, d);
        wr(8'h10, 32'h5b);
        repeat (20) @(posedge sys_clk_in);
        cnt_hi(); chk(32'd32, hi);
        wr(8'h10, 32'h58);
        repeat (20) @(posedge sys_clk_in);
        cnt_hi(); chk(32'h0, hi);
        $display("pwm test done");
        give_verdict();
    end
endmodule
